// ===== pkg/stpmc_pkg.sv
`default_nettype none
package stpmc_pkg;
  // ----------------------------------------
  // serial word and register select
  // ----------------------------------------
  localparam int WORD_W = 24;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_FREQ = 3'h0;
  localparam logic [2:0] SEL_MOD = 3'h1;
  localparam logic [2:0] SEL_PHASE = 3'h2;
  localparam logic [2:0] SEL_TIMER = 3'h4;
  localparam logic [2:0] SEL_PD = 3'h5;
  localparam logic [2:0] SEL_MUX = 3'h6;
  // ----------------------------------------
  // field layouts
  // ----------------------------------------
  localparam int FRACTION_NUMERATOR_LSB = 3;
  localparam int FRACTION_NUMERATOR_W = 12;
  localparam int INT_LSB = 15;
  localparam int INT_W = 8;
  localparam int MOD_LSB = 3;
  localparam int RCODE_LSB = 15;
  localparam int RCODE_W = 4;
  localparam int HALVE_BIT = 19;
  localparam int DOUBLER_BIT = 20;
  localparam int PHASE_LSB = 3;
  localparam int TSEL_LSB = 3;
  localparam int TMR_LSB = 5;
  localparam int TMR_W = 9;
  localparam logic [1:0] TSEL_RES = 2'h0;
  localparam logic [1:0] TSEL_SHUNT = 2'h1;
  localparam logic [1:0] TSEL_ICP = 2'h2;
  localparam int PD_W = 8;
  localparam int PD_AMP_HI = 7;
  localparam int PD_AMP_LO = 6;
  localparam int PD_CP = 5;
  localparam int PD_TRI = 4;
  localparam int PD_CRST = 3;
  localparam logic [7:0] PD_RESET = 8'hfd;
  localparam int MODE_LSB = 12;
  localparam logic [3:0] MODE_DEFAULT = 4'h0;
  localparam logic [3:0] MODE_DITHER = 4'h3;
  localparam logic [3:0] MODE_TH_WIDE = 4'h9;
  localparam int DIAG_LSB = 3;
  localparam logic [3:0] DIAG_REF_DIV = 4'h1;
  localparam logic [3:0] DIAG_INT_DIV = 4'h2;
  localparam logic [3:0] DIAG_TIMEOUT = 4'h3;
  localparam logic [3:0] DIAG_LOCK = 4'h4;
  // ----------------------------------------
  // arithmetic and timing
  // ----------------------------------------
  localparam logic [11:0] MOD_MIN = 12'h00d;
  localparam logic [11:0] MOD_MIN_DITHER = 12'h032;
  localparam logic [1:0] QTR_LAST = 2'h3;
  localparam logic [2:0] PUMP_LOG_MAX = 3'h6;
  localparam int PS_PER_NS = 1000;
  localparam int LOCK_TH_NARROW_NS = 3;
  localparam int LOCK_TH_WIDE_NS = 10;
  localparam logic [15:0] LOCK_TH_NARROW_PS = 16'(LOCK_TH_NARROW_NS * PS_PER_NS);
  localparam logic [15:0] LOCK_TH_WIDE_PS = 16'(LOCK_TH_WIDE_NS * PS_PER_NS);
  localparam logic [15:0] LFSR_SEED = 16'h0001;
  // ----------------------------------------
  // host apb map
  // ----------------------------------------
  localparam logic [11:0] HOST_TX_OFF = 12'h000;
  localparam logic [11:0] HOST_STAT_OFF = 12'h004;
endpackage
`default_nettype wire

// ===== pkg/stpmc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stpmc_link_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  modport host_end (
    output sclk,
    output sdata,
    output load_strobe
  );
  modport dev_end (
    input sclk,
    input sdata,
    input load_strobe
  );
endinterface
`default_nettype wire

// ===== rtl/stpmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module stpmc_host
  import stpmc_pkg::*;
#(
  parameter int SCLK_HALF = 6
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  stpmc_link_if.host_end link
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_LATCH} stpmc_hstate_t;

  stpmc_hstate_t st_r;
  logic [WORD_W-1:0] sh_r;
  logic [4:0] bits_r;
  logic [7:0] div_r;
  logic sclk_r;
  logic sdata_r;
  logic strobe_r;
  logic [31:0] prdata_r;
  logic busy;
  logic hit_tx;
  logic hit_stat;
  logic take;
  logic half_end;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign busy = (st_r != H_IDLE);
  assign hit_tx = (paddr == HOST_TX_OFF);
  assign hit_stat = (paddr == HOST_STAT_OFF);
  // a word written while a shift runs is stalled, not dropped
  assign pready = ~(psel & penable & pwrite & hit_tx & busy);
  assign pslverr = psel & penable & ~(hit_tx | hit_stat);
  assign take = psel & penable & pwrite & hit_tx & ~busy;
  assign prdata = prdata_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      prdata_r <= 32'h0000_0000;
    else if (psel & ~penable)
      prdata_r <= (paddr == HOST_STAT_OFF) ? {31'h000_0000, busy} : 32'h0000_0000;
  end

  // ----------------------------------------
  // three-wire shifter, msb first
  // ----------------------------------------
  assign half_end = (div_r == 8'(SCLK_HALF - 1));

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      div_r <= 8'h00;
    else if (st_r == H_IDLE || half_end)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= H_IDLE;
      sh_r <= '0;
      bits_r <= 5'h00;
      sclk_r <= 1'b0;
      sdata_r <= 1'b0;
      strobe_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        H_IDLE:
          if (take)
          begin
            sh_r <= pwdata[WORD_W-1:0];
            sdata_r <= pwdata[WORD_W-1];
            bits_r <= 5'(WORD_W - 1);
            st_r <= H_LOW;
          end
        H_LOW:
          if (half_end)
          begin
            sclk_r <= 1'b1;
            st_r <= H_HIGH;
          end
        H_HIGH:
          if (half_end)
          begin
            sclk_r <= 1'b0;
            if (bits_r == 5'h00)
            begin
              // select bits went last; strobe latches the word
              strobe_r <= 1'b1;
              st_r <= H_LATCH;
            end
            else
            begin
              sh_r <= {sh_r[WORD_W-2:0], 1'b0};
              sdata_r <= sh_r[WORD_W-2];
              bits_r <= bits_r - 5'h01;
              st_r <= H_LOW;
            end
          end
        H_LATCH:
          if (half_end)
          begin
            strobe_r <= 1'b0;
            st_r <= H_IDLE;
          end
        default:
          st_r <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.sdata = sdata_r;
  assign link.load_strobe = strobe_r;
endmodule
`default_nettype wire

// ===== rtl/stpmc_device.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module stpmc_device
  import stpmc_pkg::*;
#(
  parameter int LOCK_COUNT = 8
)
(
  stpmc_link_if.dev_end link,
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ref_tick,
  input wire logic [15:0] phase_err_ps,
  output logic phase_detector_tick,
  output logic [8:0] fb_divide,
  output logic shunt_switch_closed,
  output logic loop_resistor_closed,
  output logic [6:0] pump_current_scale,
  output logic charge_pump_hiz,
  output logic amp_powerdown,
  output logic ref_buffer_en,
  output logic dither_active,
  output logic lock_detect,
  output logic diag_out
);
  // ----------------------------------------
  // link synchronisers and word capture
  // ----------------------------------------
  logic [2:0] sclk_s;
  logic [1:0] data_s;
  logic [2:0] le_s;
  logic sclk_rise;
  logic le_rise;
  logic [WORD_W-1:0] sh_r;
  logic [SEL_W-1:0] sel;
  logic freq_wr;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_s <= 3'h0;
      data_s <= 2'h0;
      le_s <= 3'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      data_s <= {data_s[0], link.sdata};
      le_s <= {le_s[1:0], link.load_strobe};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign le_rise = le_s[1] & ~le_s[2];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sh_r <= '0;
    else if (sclk_rise)
      sh_r <= {sh_r[WORD_W-2:0], data_s[1]};
  end

  assign sel = sh_r[SEL_W-1:0];
  assign freq_wr = le_rise & (sel == SEL_FREQ);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [WORD_W-1:0] freq_sh_r;
  logic [WORD_W-1:0] mod_sh_r;
  logic [11:0] phase_sh_r;
  logic [TMR_W-1:0] tcfg_r [3];
  logic [PD_W-1:0] pd_r;
  logic dither_en_r;
  logic th_wide_r;
  logic [3:0] diag_sel_r;
  logic amp_pd_r;
  logic [1:0] tsel;

  assign tsel = sh_r[TSEL_LSB +: 2];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      freq_sh_r <= '0;
      mod_sh_r <= '0;
      phase_sh_r <= '0;
      tcfg_r <= '{default: '0};
      pd_r <= PD_RESET;
      dither_en_r <= 1'b0;
      th_wide_r <= 1'b0;
      diag_sel_r <= 4'h0;
    end
    else if (le_rise)
    begin
      case (sel)
        SEL_FREQ: freq_sh_r <= sh_r;
        SEL_MOD: mod_sh_r <= sh_r;
        SEL_PHASE: phase_sh_r <= sh_r[PHASE_LSB +: 12];
        SEL_TIMER:
          // one timer per write; code 11 loads nothing
          if (tsel != 2'h3)
            tcfg_r[tsel] <= sh_r[TMR_LSB +: TMR_W];
        SEL_PD: pd_r <= sh_r[PD_W-1:0];
        SEL_MUX:
        begin
          // other mode codes leave the modes as they are
          case (sh_r[MODE_LSB +: 4])
            MODE_DEFAULT:
            begin
              dither_en_r <= 1'b0;
              th_wide_r <= 1'b0;
            end
            MODE_DITHER: dither_en_r <= 1'b1;
            MODE_TH_WIDE: th_wide_r <= 1'b1;
            default: th_wide_r <= th_wide_r;
          endcase
          diag_sel_r <= sh_r[DIAG_LSB +: 4];
        end
        default: pd_r <= pd_r;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      amp_pd_r <= 1'b1;
    else if (pd_r[PD_AMP_HI] & pd_r[PD_AMP_LO])
      amp_pd_r <= 1'b1;
    else if (~pd_r[PD_AMP_HI] & ~pd_r[PD_AMP_LO])
      amp_pd_r <= 1'b0;
  end

  // ----------------------------------------
  // reference divider, detector rate
  // ----------------------------------------
  logic hold;
  logic [RCODE_W-1:0] rcode;
  logic [5:0] target;
  logic [5:0] racc_r;
  logic [5:0] racc_nxt;
  logic pfd_tick;

  assign hold = pd_r[PD_CP] | pd_r[PD_CRST];
  assign rcode = (mod_sh_r[RCODE_LSB +: RCODE_W] == 4'h0) ? 4'h1 : mod_sh_r[RCODE_LSB +: RCODE_W];
  assign target = mod_sh_r[HALVE_BIT] ? {1'b0, rcode, 1'b0} : {2'b00, rcode};
  assign racc_nxt = racc_r + (mod_sh_r[DOUBLER_BIT] ? 6'h02 : 6'h01);
  assign pfd_tick = ref_tick & ~hold & (racc_nxt >= target);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      racc_r <= 6'h00;
    else if (hold)
      racc_r <= 6'h00;
    else if (ref_tick)
      racc_r <= pfd_tick ? racc_nxt - target : racc_nxt;
  end

  // ----------------------------------------
  // frequency word apply
  // ----------------------------------------
  logic pend_r;
  logic apply;
  logic [INT_W-1:0] int_r;
  logic [FRACTION_NUMERATOR_W-1:0] fraction_numerator_r;
  logic [11:0] mod_r;

  assign apply = pfd_tick & pend_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pend_r <= 1'b0;
    else if (freq_wr)
      pend_r <= 1'b1;
    else if (apply)
      pend_r <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      int_r <= '0;
      fraction_numerator_r <= '0;
      mod_r <= MOD_MIN;
    end
    else if (apply)
    begin
      int_r <= freq_sh_r[INT_LSB +: INT_W];
      fraction_numerator_r <= freq_sh_r[FRACTION_NUMERATOR_LSB +: FRACTION_NUMERATOR_W];
      mod_r <= mod_sh_r[MOD_LSB +: 12];
    end
  end

  // ----------------------------------------
  // third-order modulator
  // ----------------------------------------
  logic [11:0] mod_eff;
  logic dith;
  logic [15:0] lfsr_r;
  logic [12:0] acc_r [3];
  logic [12:0] stg_in [3];
  logic [12:0] sum [3];
  logic [12:0] acc_nxt [3];
  logic [2:0] cy;
  logic [2:0] cy_r;
  logic c2d_r;
  logic c3d_r;
  logic c3dd_r;
  logic signed [3:0] sdm_y;

  assign dither_active = dither_en_r & (mod_r >= MOD_MIN_DITHER);
  assign mod_eff = (mod_r < (dither_en_r ? MOD_MIN_DITHER : MOD_MIN)) ?
                   (dither_en_r ? MOD_MIN_DITHER : MOD_MIN) : mod_r;
  assign dith = dither_active & lfsr_r[0];

  always_comb
  begin
    stg_in[0] = {1'b0, fraction_numerator_r} + {12'h000, dith};
    for (int k = 1; k < 3; k++)
      stg_in[k] = acc_r[k-1];
    for (int k = 0; k < 3; k++)
    begin
      sum[k] = acc_r[k] + stg_in[k];
      cy[k] = (sum[k] >= {1'b0, mod_eff});
      acc_nxt[k] = cy[k] ? sum[k] - {1'b0, mod_eff} : sum[k];
    end
  end

  // cascade of three first-order stages with noise-cancelling sum
  assign sdm_y = $signed({3'b000, cy_r[0]}) + $signed({3'b000, cy_r[1]})
               - $signed({3'b000, c2d_r}) + $signed({3'b000, cy_r[2]})
               - $signed({2'b00, c3d_r, 1'b0}) + $signed({3'b000, c3dd_r});

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_r <= '{default: '0};
      cy_r <= 3'h0;
      c2d_r <= 1'b0;
      c3d_r <= 1'b0;
      c3dd_r <= 1'b0;
      lfsr_r <= LFSR_SEED;
    end
    else if (hold)
    begin
      acc_r <= '{default: '0};
      cy_r <= 3'h0;
    end
    else if (apply)
    begin
      acc_r[0] <= {1'b0, phase_sh_r}; // phase seed takes effect here
      acc_r[1] <= '0;
      acc_r[2] <= '0;
    end
    else if (pfd_tick)
    begin
      acc_r <= acc_nxt;
      cy_r <= cy;
      c2d_r <= cy_r[1];
      c3d_r <= cy_r[2];
      c3dd_r <= c3d_r;
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  logic [8:0] fb_r;
  logic int_div_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fb_r <= '0;
      int_div_r <= 1'b0;
    end
    else
    begin
      int_div_r <= pfd_tick;
      if (pfd_tick)
        fb_r <= {1'b0, int_r} + {{5{sdm_y[3]}}, sdm_y};
    end
  end

  // ----------------------------------------
  // fast-lock timers
  // ----------------------------------------
  logic [1:0] q_r;
  logic qtick;
  logic [TMR_W-1:0] cnt_r [3];
  logic [2:0] exp_r;
  logic [2:0] pump_log_r;

  assign qtick = pfd_tick & (q_r == QTR_LAST);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      q_r <= 2'h0;
    else if (hold | apply)
      q_r <= 2'h0;
    else if (pfd_tick)
      q_r <= q_r + 2'h1;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= '{default: '0};
      exp_r <= 3'h7;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (hold)
        begin
          cnt_r[i] <= '0;
          exp_r[i] <= 1'b1;
        end
        else if (apply)
        begin
          cnt_r[i] <= tcfg_r[i];
          exp_r[i] <= (tcfg_r[i] == '0);
        end
        else if (qtick & ~exp_r[i])
        begin
          cnt_r[i] <= cnt_r[i] - 9'h001;
          exp_r[i] <= (cnt_r[i] == 9'h001);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pump_log_r <= 3'h0;
    else if (hold)
      pump_log_r <= 3'h0;
    else if (apply)
      pump_log_r <= PUMP_LOG_MAX;
    else if (qtick & exp_r[TSEL_ICP] & (pump_log_r != 3'h0))
      pump_log_r <= pump_log_r - 3'h1;
  end

  assign shunt_switch_closed = ~exp_r[TSEL_SHUNT];
  assign loop_resistor_closed = ~exp_r[TSEL_RES];
  assign pump_current_scale = 7'h01 << pump_log_r;

  // ----------------------------------------
  // lock detect and diagnostic mux
  // ----------------------------------------
  logic [7:0] lock_cnt_r;
  logic [15:0] lock_th;
  logic diag_r;

  assign lock_th = th_wide_r ? LOCK_TH_WIDE_PS : LOCK_TH_NARROW_PS;
  assign lock_detect = (lock_cnt_r == 8'(LOCK_COUNT));

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      lock_cnt_r <= 8'h00;
    else if (hold)
      lock_cnt_r <= 8'h00;
    else if (pfd_tick)
    begin
      if (phase_err_ps >= lock_th)
        lock_cnt_r <= 8'h00;
      else if (!lock_detect)
        lock_cnt_r <= lock_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      diag_r <= 1'b0;
    else
    begin
      case (diag_sel_r)
        DIAG_REF_DIV: diag_r <= pfd_tick;
        DIAG_INT_DIV: diag_r <= int_div_r;
        DIAG_TIMEOUT: diag_r <= ~exp_r[TSEL_ICP];
        DIAG_LOCK: diag_r <= lock_detect;
        default: diag_r <= 1'b0;
      endcase
    end
  end

  assign diag_out = diag_r;
  assign phase_detector_tick = pfd_tick;
  assign fb_divide = fb_r;
  assign charge_pump_hiz = pd_r[PD_TRI] | pd_r[PD_CP];
  assign amp_powerdown = amp_pd_r;
  assign ref_buffer_en = ~pd_r[PD_CP];
endmodule
`default_nettype wire

// ===== verification/stpmc_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module stpmc_link_assertions #(
  parameter int SCLK_HALF = 6
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe
);
  // ----
  // frame counters
  // ----
  logic [4:0] bits_r;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  logic [7:0] st_r;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      bits_r <= '0;
    else if (load_strobe)
      bits_r <= '0;
    else if ($rose(sclk))
      bits_r <= bits_r + 5'h01;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hi_r <= '0;
      lo_r <= '0;
      st_r <= '0;
    end
    else
    begin
      hi_r <= sclk ? hi_r + 8'h01 : 8'h00;
      lo_r <= sclk ? 8'h00 : lo_r + 8'h01;
      st_r <= load_strobe ? st_r + 8'h01 : 8'h00;
    end
  end
  // ----
  // wire timing
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_hi_len; $fell(sclk) |-> hi_r == SCLK_HALF; endproperty
  a_hi_len: assert property (p_hi_len) else $error("sclk high time wrong");
  property p_lo_len; $rose(sclk) && bits_r != 0 |-> lo_r == SCLK_HALF; endproperty
  a_lo_len: assert property (p_lo_len) else $error("sclk low time wrong");
  property p_st_len; $fell(load_strobe) |-> st_r == SCLK_HALF; endproperty
  a_st_len: assert property (p_st_len) else $error("strobe length wrong");
  property p_st_bits; $rose(load_strobe) |-> bits_r == 24; endproperty
  a_st_bits: assert property (p_st_bits) else $error("strobe not after 24 bits");
  property p_no_extra; $rose(sclk) |-> bits_r < 24; endproperty
  a_no_extra: assert property (p_no_extra) else $error("more than 24 bits");
  property p_hold; sclk |-> $stable(sdata); endproperty
  a_hold: assert property (p_hold) else $error("data moved while sclk high");
  property p_st_low; load_strobe |-> !sclk; endproperty
  a_st_low: assert property (p_st_low) else $error("sclk high during strobe");
  property p_st_soon; $fell(sclk) && bits_r == 24 |-> ##[0:8] load_strobe; endproperty
  a_st_soon: assert property (p_st_soon) else $error("strobe missing after word");
endmodule
`default_nettype wire

// ===== verification/stpmc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("BAD %s exp %0h got %0h", nm, (exp), (got)); \
    end \
  end
module stpmc_tb_top;
  import stpmc_pkg::*;
  localparam int HALF = 4;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, tick, shut, rsw, hiz, ampd, refb, dith, lock, diag;
  logic ref_tick = 1'b0;
  logic [15:0] phase_err_ps = 16'h1388;
  logic [8:0] fbd;
  logic [6:0] pump;
  logic [6:0] pq[$];
  logic [6:0] pprev = 7'h01;
  logic [31:0] lfsr = 32'h0001_0dce;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int sh_n, rs_n, dg_n, tk_n;
  stpmc_link_if stpmc_link_if_i ();
  stpmc_host #(.SCLK_HALF(HALF)) stpmc_host_i (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(stpmc_link_if_i.host_end));
  stpmc_device #(.LOCK_COUNT(2)) stpmc_device_i (.link(stpmc_link_if_i.dev_end), .clock(clock),
    .rst_b(rst_b), .ref_tick(ref_tick), .phase_err_ps(phase_err_ps), .phase_detector_tick(tick),
    .fb_divide(fbd), .shunt_switch_closed(shut), .loop_resistor_closed(rsw),
    .pump_current_scale(pump), .charge_pump_hiz(hiz), .amp_powerdown(ampd),
    .ref_buffer_en(refb), .dither_active(dith), .lock_detect(lock), .diag_out(diag));
  stpmc_link_assertions #(.SCLK_HALF(HALF)) stpmc_link_assertions_i (.clock(clock),
    .rst_b(rst_b), .sclk(stpmc_link_if_i.sclk), .sdata(stpmc_link_if_i.sdata),
    .load_strobe(stpmc_link_if_i.load_strobe));
  // ----
  // clock, reference, monitors
  // ----
  initial
  begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    ref_tick <= (cyc % 3 == 0);
    if (tick === 1'b1)
    begin
      tk_n += 1;
      sh_n += (shut === 1'b1);
      rs_n += (rsw === 1'b1);
      dg_n += (diag === 1'b1);
    end
    if (pump !== pprev)
      pq.push_back(pump);
    pprev = pump;
    if (cyc == 60000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  // ----
  // helpers
  // ----
  function automatic int rnd(input int n);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return int'(lfsr % n);
  endfunction
  function automatic logic [23:0] tmr(input logic [1:0] ts, input int v);
    return {10'h001, 9'(v), ts, SEL_TIMER};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [23:0] w);
    logic [31:0] rd;
    logic e;
    apb(1'b1, HOST_TX_OFF, {8'h00, w}, rd, e);
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0)
      apb(1'b0, HOST_STAT_OFF, 32'h0000_0000, rd, e);
    repeat (8) @(posedge clock);
  endtask
  task automatic hop(input int p, input int s, input int r);
    int i;
    logic [7:0] n;
    n = 8'(rnd(256));
    send(tmr(TSEL_ICP, p));
    send(tmr(TSEL_SHUNT, s));
    send(tmr(TSEL_RES, r));
    send(tmr(2'h3, 0));
    sh_n = 0;
    rs_n = 0;
    dg_n = 0;
    pq.delete();
    send({1'b0, n, 12'h000, SEL_FREQ});
    `CHK("fbdiv", {1'b0, n}, fbd)
    for (i = 0; i < 3000 && ((shut | rsw) !== 1'b0 || pump !== 7'h01); i++)
      @(posedge clock);
    `CHK("shunt", 1'b1, sh_n inside {[4 * s - 3 : 4 * s]})
    `CHK("resist", 1'b1, rs_n inside {[4 * r - 3 : 4 * r]})
    `CHK("window", 1'b1, dg_n inside {[4 * p - 3 : 4 * p]})
    for (i = 0; i < 7; i++)
      `CHK("pump", 7'h40 >> i, pq[i])
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    logic [31:0] rd;
    logic e;
    logic [7:0] v;
    logic amp_e;
    logic [3:0] md[4];
    int i;
    int p;
    md = '{MODE_TH_WIDE, MODE_DEFAULT, MODE_DITHER, MODE_DEFAULT};
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    `CHK("amp", 1'b1, ampd)
    `CHK("hiz", 1'b1, hiz)
    `CHK("refbuf", 1'b0, refb)
    `CHK("switch", 1'b0, shut)
    apb(1'b0, 12'h010, 32'h0000_0000, rd, e);
    `CHK("slverr", 1'b1, e)
    `CHK("unmapped", 32'h0000_0000, rd)
    send({16'h0000, PD_RESET});
    send({8'h00, MODE_DEFAULT, 5'h01, DIAG_TIMEOUT, SEL_MUX});
    send({9'h000, 12'h000, SEL_PHASE});
    send({5'h00, 4'h1, 12'h041, SEL_MOD});
    send({1'b0, 8'h21, 12'h000, SEL_FREQ});
    amp_e = 1'b1;
    for (i = 0; i < 10; i++)
    begin
      v = (i < 4) ? {i[0], i[1], i[0], i[1], 4'h5} : {5'(rnd(32)), 3'h5};
      if (i == 9)
        v = 8'h05;
      send({16'h0000, v});
      amp_e = (v[7] & v[6]) ? 1'b1 : (v[7] | v[6]) ? amp_e : 1'b0;
      `CHK("amp", amp_e, ampd)
      `CHK("hiz", v[4] | v[5], hiz)
      `CHK("refbuf", ~v[5], refb)
    end
    hop(1, 8, 0);
    send({16'h0000, 8'h0d});
    send({1'b0, 8'h21, 12'h000, SEL_FREQ});
    repeat (30) @(posedge clock);
    `CHK("held", 1'b0, shut)
    send({16'h0000, 8'h05});
    for (i = 0; i < 3; i++)
    begin
      p = 1 + rnd(8);
      hop(p, p + 7, p + 7);
    end
    for (i = 0; i < 4; i++)
    begin
      send({8'h00, md[i], 5'h01, DIAG_LOCK, SEL_MUX});
      repeat (40) @(posedge clock);
      `CHK("lock", i == 0, lock)
      `CHK("dither", i == 2, dith)
      `CHK("diag", i == 0, diag)
    end
    // r code 3 with halver: one detector tick per six reference ticks
    send({3'h0, 1'b0, 1'b1, 4'h3, 12'h041, SEL_MOD});
    tk_n = 0;
    repeat (360) @(posedge clock);
    `CHK("rate", 1'b1, tk_n inside {[19 : 21]})
    end_of_test();
  end
endmodule
`default_nettype wire
